// ==== rtl/pin_cfg_pkg.sv ====
// constants for the upper pin configuration block (pins 5 to 9)
// assumes a 32-bit register port with read data one cycle after the strobe
package pin_cfg_pkg;

   localparam int          NUM_PINS      = 5;
   localparam int          FIRST_PIN     = 5;
   localparam int          ADDR_W        = 12;
   localparam int          SEL_W         = 3;
   localparam int          MARK_ADDR_W   = 3;

   // register offsets
   localparam logic [11:0] SEL_REG_OFS   = 12'h008;
   localparam logic [11:0] PIN_CFG_OFS   = 12'h00c;
   localparam logic [11:0] MARK_CFG_OFS  = 12'h010;
   localparam logic [11:0] IRQ_STAT_OFS  = 12'h014;
   localparam logic [11:0] IRQ_MASK_OFS  = 12'h018;

   // pin_config_reg field layout: per pin, flag/out/in from this bit up
   localparam int          FIELD_BASE    = 16;
   localparam int          FIELD_STRIDE  = 3;
   localparam int          FLAG_POS      = 0;
   localparam int          OUT_POS       = 1;
   localparam int          IN_POS        = 2;
   localparam int          RSVD_HI_POS   = 31;
   localparam int          RSVD_LO_POS   = 15;

   // source select layout: pin n field at 3*(n-5)+16
   localparam int          SEL_BASE      = 16;

   // reset values
   localparam logic [31:0] PIN_CFG_RST   = 32'h0000_0000;
   localparam logic [2:0]  SEL_RST       = 3'h0;
   localparam logic [4:0]  MASK_RST      = 5'h00;

   // source select encodings
   localparam logic [2:0]  SEL_GP_IN     = 3'h0;
   localparam logic [2:0]  SEL_MARK0     = 3'h1;
   localparam logic [2:0]  SEL_MARK1     = 3'h2;
   localparam logic [2:0]  SEL_GP_OUT    = 3'h7;

   localparam int          SYNC_STAGES   = 3;

endpackage : pin_cfg_pkg

// ==== rtl/pin_sync_detect.sv ====
// one pin: three-stage synchroniser and level change detector
// assumes the pin is asynchronous to clk
`timescale 1ns/10ps
module pin_sync_detect (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // pin side
   input  wire logic pin_in,
   // core side
   output logic      level,
   output logic      change
);

   logic [2:0] sync;

   // second and third stage agree before a change counts
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync  <= 3'h0;
         level <= 1'b0;
      end else begin
         sync <= {sync[1:0], pin_in};
         if (sync[1] == sync[2]) begin
            level <= sync[2];
         end
      end
   end

   // one pulse per change of the filtered level
   assign change = (sync[1] == sync[2]) && (sync[2] != level);

endmodule : pin_sync_detect

// ==== rtl/pin_io_config_upper.sv ====
// upper half of the pin configuration register: pins 5 to 9
// assumes a simple strobe register port and asynchronous pins
//
// Overview of operation
// - Bits 31 and 15 ignore writes and always read as zero.
// - Input bits 30, 27, 24, 21 and 18 show the level of pins 9 to 5.
// - Output bits 29, 26, 23, 20, 17 are stored and drive a pin set as output.
// - Status bits 28, 25, 22, 19, 16 set on any rising or falling pin change.
// - Setting a status bit also raises that pin's interrupt when enabled.
// - Writing 1 clears a status bit until the next change; 0 leaves it.
// - Watermarks apply only to the buffer whose address the host presents.
// - Select 000 makes a pin a general input, 111 a general output.
`timescale 1ns/10ps
module pin_io_config_upper #(
   parameter int NUM_PINS = pin_cfg_pkg::NUM_PINS
) (
   // clock and reset
   input  wire logic                    clk,
   input  wire logic                    rst_n,
   // register port
   input  wire logic [11:0]             reg_addr,
   input  wire logic [31:0]             reg_wdata,
   input  wire logic                    reg_wr,
   input  wire logic                    reg_rd,
   output logic      [31:0]             reg_rdata,
   // pins
   input  wire logic [NUM_PINS-1:0]     pin_in,
   output logic      [NUM_PINS-1:0]     pin_out,
   output logic      [NUM_PINS-1:0]     pin_oe,
   // watermark sources for pins
   input  wire logic [2:0]              highspeed_port_buffer_addr,
   input  wire logic [2:0]              mark0_buffer_sel,
   input  wire logic [2:0]              mark1_buffer_sel,
   input  wire logic                    mark0_level,
   input  wire logic                    mark1_level,
   // interrupts
   output logic      [NUM_PINS-1:0]     system_pin_interrupt,
   output logic                         irq
);

   localparam int FB = pin_cfg_pkg::FIELD_BASE;
   localparam int FS = pin_cfg_pkg::FIELD_STRIDE;
   localparam int SB = pin_cfg_pkg::SEL_BASE;

   logic [NUM_PINS-1:0] level;
   logic [NUM_PINS-1:0] change;
   logic [NUM_PINS-1:0] output_value;
   logic [NUM_PINS-1:0] change_flag;
   logic [NUM_PINS-1:0] int_status;
   logic [NUM_PINS-1:0] int_mask;
   logic [2:0]          source_select [NUM_PINS];
   logic [2:0]          mark0_sel;
   logic [2:0]          mark1_sel;
   logic [31:0]         cfg_word;
   logic [31:0]         sel_word;
   logic [NUM_PINS-1:0] flag_clear;
   logic [2:0]          addr_meta;
   logic [2:0]          addr_mid;
   logic [2:0]          addr_late;
   logic [2:0]          buffer_addr;
   logic                mark0_hit;
   logic                mark1_hit;
   logic [31:0]         next_rdata;
   logic                wr_cfg;
   logic                wr_sel;
   logic                wr_mask;
   logic                rd_stat;

   // register decodes
   assign wr_cfg  = reg_wr && (reg_addr == pin_cfg_pkg::PIN_CFG_OFS);
   assign wr_sel  = reg_wr && (reg_addr == pin_cfg_pkg::SEL_REG_OFS);
   assign wr_mask = reg_wr && (reg_addr == pin_cfg_pkg::IRQ_MASK_OFS);
   assign rd_stat = reg_rd && (reg_addr == pin_cfg_pkg::IRQ_STAT_OFS);

   // one synchroniser and change detector per pin
   genvar g;
   generate
      for (g = 0; g < NUM_PINS; g++) begin : g_pin
         pin_sync_detect u_sync (
            .clk    (clk),
            .rst_n  (rst_n),
            .pin_in (pin_in[g]),
            .level  (level[g]),
            .change (change[g])
         );
      end
   endgenerate

   // output values; reserved bits are never stored
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         output_value <= '0;
      end else if (wr_cfg) begin
         for (int i = 0; i < NUM_PINS; i++) begin
            output_value[i] <= reg_wdata[FB + FS*i + pin_cfg_pkg::OUT_POS];
         end
      end
   end

   // source selects for pins 5 to 9 only; lower fields kept elsewhere
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < NUM_PINS; i++) begin
            source_select[i] <= pin_cfg_pkg::SEL_RST;
         end
      end else if (wr_sel) begin
         for (int i = 0; i < NUM_PINS; i++) begin
            source_select[i] <= reg_wdata[SB + 3*i +: 3];
         end
      end
   end

   // write-one-to-clear requests, one per pin
   always_comb begin
      flag_clear = '0;
      for (int i = 0; i < NUM_PINS; i++) begin
         flag_clear[i] = wr_cfg &&
                         reg_wdata[FB + FS*i + pin_cfg_pkg::FLAG_POS];
      end
   end

   // change flags: a change in the clearing cycle wins
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         change_flag <= '0;
      end else begin
         for (int i = 0; i < NUM_PINS; i++) begin
            if (change[i]) begin
               change_flag[i] <= 1'b1;
            end else if (flag_clear[i]) begin
               change_flag[i] <= 1'b0;
            end
         end
      end
   end

   // system interrupt entry follows the flag when enabled
   always_comb begin
      system_pin_interrupt = change_flag & int_mask;
   end

   // sticky interrupt status, cleared by reading it; set wins
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         int_status <= '0;
      end else begin
         for (int i = 0; i < NUM_PINS; i++) begin
            if (change[i]) begin
               int_status[i] <= 1'b1;
            end else if (rd_stat) begin
               int_status[i] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         int_mask <= pin_cfg_pkg::MASK_RST;
      end else if (wr_mask) begin
         int_mask <= reg_wdata[NUM_PINS-1:0];
      end
   end

   // level output: stays high until the status read or a mask write clears it
   assign irq = |(int_status & int_mask);

   // watermark buffer choice held by software
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mark0_sel <= 3'h0;
         mark1_sel <= 3'h0;
      end else if (reg_wr && (reg_addr == pin_cfg_pkg::MARK_CFG_OFS)) begin
         mark0_sel <= reg_wdata[2:0];
         mark1_sel <= reg_wdata[6:4];
      end
   end

   // buffer address lines are asynchronous: three flops, whole word agrees
   // costs four cycles of latency on a new address
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         addr_meta   <= 3'h0;
         addr_mid    <= 3'h0;
         addr_late   <= 3'h0;
         buffer_addr <= 3'h0;
      end else begin
         addr_meta <= highspeed_port_buffer_addr;
         addr_mid  <= addr_meta;
         addr_late <= addr_mid;
         // a word caught mid-change never reaches buffer_addr
         if (addr_mid == addr_late) begin
            buffer_addr <= addr_late;
         end
      end
   end

   // a watermark reaches a pin only for the buffer addressed by the host
   assign mark0_hit = mark0_level && (buffer_addr == mark0_sel);
   assign mark1_hit = mark1_level && (buffer_addr == mark1_sel);

   // pin drivers; watermark only counts for the addressed buffer
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_out <= '0;
         pin_oe  <= '0;
      end else begin
         for (int i = 0; i < NUM_PINS; i++) begin
            case (source_select[i])
               pin_cfg_pkg::SEL_GP_IN: begin
                  pin_out[i] <= 1'b0;
                  pin_oe[i]  <= 1'b0;
               end
               pin_cfg_pkg::SEL_GP_OUT: begin
                  pin_out[i] <= output_value[i];
                  pin_oe[i]  <= 1'b1;
               end
               pin_cfg_pkg::SEL_MARK0: begin
                  pin_out[i] <= mark0_hit;
                  // pin5 has no watermark function, so it stays released
                  pin_oe[i]  <= (i != 0);
               end
               pin_cfg_pkg::SEL_MARK1: begin
                  pin_out[i] <= mark1_hit;
                  pin_oe[i]  <= (i != 0);
               end
               default: begin
                  // other functions are served outside this block
                  pin_out[i] <= 1'b0;
                  pin_oe[i]  <= 1'b0;
               end
            endcase
         end
      end
   end

   // pin_config_reg image; reserved bits stay zero
   always_comb begin
      cfg_word = 32'h0000_0000;
      for (int i = 0; i < NUM_PINS; i++) begin
         cfg_word[FB + FS*i + pin_cfg_pkg::IN_POS]   = level[i];
         cfg_word[FB + FS*i + pin_cfg_pkg::OUT_POS]  = output_value[i];
         cfg_word[FB + FS*i + pin_cfg_pkg::FLAG_POS] = change_flag[i];
      end
   end

   // source select image; fields of pins 0 to 4 read zero here
   always_comb begin
      sel_word = 32'h0000_0000;
      for (int i = 0; i < NUM_PINS; i++) begin
         sel_word[SB + 3*i +: 3] = source_select[i];
      end
   end

   // read mux; bits 31 and 15 and unmapped offsets read zero
   always_comb begin
      next_rdata = 32'h0000_0000;
      case (reg_addr)
         pin_cfg_pkg::PIN_CFG_OFS: begin
            next_rdata = cfg_word;
         end
         pin_cfg_pkg::SEL_REG_OFS: begin
            next_rdata = sel_word;
         end
         pin_cfg_pkg::MARK_CFG_OFS: begin
            next_rdata[2:0] = mark0_sel;
            next_rdata[6:4] = mark1_sel;
         end
         pin_cfg_pkg::IRQ_STAT_OFS: begin
            next_rdata[NUM_PINS-1:0] = int_status;
         end
         pin_cfg_pkg::IRQ_MASK_OFS: begin
            next_rdata[NUM_PINS-1:0] = int_mask;
         end
         default: begin
            next_rdata = 32'h0000_0000;
         end
      endcase
   end

   // read data stands for one cycle only, zero otherwise
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd) begin
         reg_rdata <= next_rdata;
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end

endmodule : pin_io_config_upper

// ==== sim/pin_cfg_checker.sv ====
// checker: port-level properties of the upper pin block
// assumes one clock domain and an async active-low reset
`timescale 1ns/10ps
module pin_cfg_checker #(
   parameter int NUM_PINS = 5
) (
   // clock and reset
   input wire logic                clk,
   input wire logic                rst_n,
   // register port
   input wire logic [11:0]         reg_addr,
   input wire logic [31:0]         reg_wdata,
   input wire logic                reg_wr,
   input wire logic                reg_rd,
   input wire logic [31:0]         reg_rdata,
   // pins and interrupts
   input wire logic [NUM_PINS-1:0] pin_in,
   input wire logic [NUM_PINS-1:0] pin_out,
   input wire logic [NUM_PINS-1:0] pin_oe,
   input wire logic [NUM_PINS-1:0] system_pin_interrupt
);
   logic rd_cfg, wr_cfg, wr_sel;
   assign rd_cfg = reg_rd && reg_addr == pin_cfg_pkg::PIN_CFG_OFS;
   assign wr_cfg = reg_wr && reg_addr == pin_cfg_pkg::PIN_CFG_OFS;
   assign wr_sel = reg_wr && reg_addr == pin_cfg_pkg::SEL_REG_OFS;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // long enough for synchroniser and detector to settle
   sequence quiet(s);
      $stable(s) [*8];
   endsequence
   AST_RSVD_ZERO: assert property (
      rd_cfg |=> !reg_rdata[31] && !reg_rdata[15])
      else $error("reserved bit read nonzero");
   AST_LEVEL_P5: assert property (
      quiet(pin_in[0]) ##0 rd_cfg |=> reg_rdata[18] == $past(pin_in[0]))
      else $error("pin5 level wrong");
   AST_LEVEL_P9: assert property (
      quiet(pin_in[4]) ##0 rd_cfg |=> reg_rdata[30] == $past(pin_in[4]))
      else $error("pin9 level wrong");
   AST_OUT_DRIVE: assert property (
      $changed(pin_out[0]) && pin_oe[0] && $past(pin_oe[0]) |->
         $past(wr_cfg) && pin_out[0] == $past(reg_wdata[17]) ||
         $past(wr_cfg, 2) && pin_out[0] == $past(reg_wdata[17], 2))
      else $error("pin5 drive changed without write");
   AST_SEL_OUT: assert property (
      wr_sel && reg_wdata[18:16] == 3'h7 |=> ##[0:1] pin_oe[0])
      else $error("pin5 not driven after output select");
   AST_SEL_IN: assert property (
      wr_sel && reg_wdata[18:16] == 3'h0 |=> ##[0:1] !pin_oe[0])
      else $error("pin5 driven after input select");
   AST_W1C: assert property (
      quiet(pin_in[0]) ##0 wr_cfg && reg_wdata[16]
      |=> !system_pin_interrupt[0])
      else $error("pin5 flag not cleared by write of one");
   AST_ONE_SET: assert property (
      quiet(pin_in[0]) ##0 !system_pin_interrupt[0] && !reg_wr
      |=> !system_pin_interrupt[0])
      else $error("pin5 flag set without a change");
endmodule : pin_cfg_checker

// ==== sim/pin_far_side.sv ====
// far side: circuitry on pins 5 to 9 and the buffer address lines
// assumes pin_oe high while the block drives a pin
`timescale 1ns/10ps
module pin_far_side (
   // block side
   input  wire logic [4:0] pin_out,
   input  wire logic [4:0] pin_oe,
   output logic      [4:0] pin_in,
   output logic      [2:0] buf_addr,
   // bench side
   input  wire logic [4:0] ext_level
);
   // block wins where it drives, else the outside level
   assign pin_in = (pin_out & pin_oe) | (ext_level & ~pin_oe);
   assign buf_addr = 3'h3;
endmodule : pin_far_side

// ==== sim/pin_io_config_upper_bench.sv ====
// bench: upper pin block, far-side model and a reference model
// assumes 100 MHz clock and reset held two cycles
`timescale 1ns/10ps
module pin_io_config_upper_bench;
   localparam logic [11:0] CFG = pin_cfg_pkg::PIN_CFG_OFS;
   logic        clk, rst_n, reg_wr, reg_rd, irq, drive;
   logic [11:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, got;
   logic [4:0]  pin_in, pin_out, pin_oe, spi, ext, out_v, flag, stat, mask;
   logic [2:0]  hs_addr;
   logic [1:0]  mark_lv;
   int          n_errors, checks_done;
   pin_io_config_upper dut_u (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe(pin_oe), .highspeed_port_buffer_addr(hs_addr),
      .mark0_buffer_sel(3'h0), .mark1_buffer_sel(3'h0),
      .mark0_level(mark_lv[0]), .mark1_level(mark_lv[1]),
      .system_pin_interrupt(spi), .irq(irq));
   pin_far_side far_u (.pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in),
      .buf_addr(hs_addr), .ext_level(ext));
   task automatic end_of_test();
      if (n_errors == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : end_of_test
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wr(logic [11:0] a, logic [31:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask : wr
   task automatic rd(logic [11:0] a);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1 got = reg_rdata;
   endtask : rd
   function automatic logic [31:0] cfg_exp();
      logic [4:0] lv;
      cfg_exp = 32'h0;
      lv = drive ? out_v : ext;
      for (int k = 0; k < 5; k++)
         cfg_exp[16+3*k +: 3] = {lv[k], out_v[k], flag[k]};
   endfunction : cfg_exp
   task automatic settle();
      repeat (8) @(posedge clk);
      rd(CFG);
      chk("cfg", cfg_exp(), got);
      chk("pin_irq", flag & mask, spi);
      chk("irq", |(stat & mask), irq);
      chk("oe", {5{drive}}, pin_oe);
      if (drive) chk("out", out_v, pin_out);
   endtask : settle
   // level seen on a pin changes: flag and status set
   task automatic toggle(logic [4:0] f);
      flag = flag | f;
      stat = stat | f;
   endtask : toggle
   task automatic flip(logic [4:0] f);
      @(posedge clk);
      ext <= ext ^ f;
      if (!drive) toggle(f);
      settle();
   endtask : flip
   task automatic drive_sel(logic d);
      wr(pin_cfg_pkg::SEL_REG_OFS, d ? 32'h7fff_0000 : 32'h0);
      toggle(out_v ^ ext);
      drive = d;
      settle();
   endtask : drive_sel
   // write-one clears come first, a pin change from new outputs after
   task automatic set_out(logic [31:0] w);
      logic [4:0] nv;
      wr(CFG, w);
      for (int k = 0; k < 5; k++) begin
         if (w[16+3*k]) flag[k] = 1'b0;
         nv[k] = w[17+3*k];
      end
      if (drive) toggle(nv ^ out_v);
      out_v = nv;
      settle();
   endtask : set_out
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      #50000;
      n_errors++;
      end_of_test();
   end
   initial begin
      rst_n = 1'b0;
      {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
      {ext, out_v, flag, stat, mask, drive} = '0;
      mark_lv = 2'h0;
      {n_errors, checks_done} = '0;
      void'($urandom(32'heef89a58));
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      settle();
      rd(12'hffc);
      chk("unmapped", 32'h0, got);
      flip(5'h01);
      wr(pin_cfg_pkg::IRQ_MASK_OFS, 32'h1f);
      mask = 5'h1f;
      for (int i = 0; i < 12; i++) begin
         flip(5'h01 << ($urandom % 5));
      end
      rd(pin_cfg_pkg::IRQ_STAT_OFS);
      chk("stat", stat, got);
      stat = 5'h00;
      rd(pin_cfg_pkg::IRQ_STAT_OFS);
      chk("stat_clr", 32'h0, got);
      drive_sel(1'b1);
      repeat (3) set_out($urandom | 32'h8001_8000);
      drive_sel(1'b0);
      set_out(32'hffff_ffff);
      // mark0 on buffer 3 (the address shown), mark1 on buffer 5
      mark_lv <= 2'h3;
      wr(pin_cfg_pkg::MARK_CFG_OFS, 32'h0000_0053);
      wr(pin_cfg_pkg::SEL_REG_OFS, 32'h0088_0000);
      repeat (3) @(posedge clk);
      chk("mark_out", 32'h2, pin_out);
      chk("mark_oe", 32'h6, pin_oe);
      end_of_test();
   end
endmodule : pin_io_config_upper_bench
bind pin_io_config_upper pin_cfg_checker #(.NUM_PINS(NUM_PINS)) chk_u (
   .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
   .system_pin_interrupt(system_pin_interrupt));
